// ==== sicfg_regs.svh ====
// register offsets, ranges, exception codes and timing constants of the config bank
`ifndef SICFG_REGS_SVH
`define SICFG_REGS_SVH
`define SICFG_REG_DEC2      8'h19
`define SICFG_REG_DEC3      8'h1A
`define SICFG_REG_DEC4      8'h1B
`define SICFG_REG_DEC5      8'h1C
`define SICFG_REG_DEC6      8'h1D
`define SICFG_REG_ADDR      8'h20
`define SICFG_REG_IDENT     8'h21
`define SICFG_REG_BAUD      8'h22
`define SICFG_REG_PERM      8'h23
`define SICFG_REG_DELAY     8'h25
`define SICFG_REG_VALREPLY  8'h26
`define SICFG_REG_GAP       8'h27
`define SICFG_REG_BRI       8'h2D
`define SICFG_REG_EDIT      8'h2F
`define SICFG_REG_TYPE      8'h30
`define SICFG_REG_VBRI      8'h31
`define SICFG_REG_VALHI     8'h01
`define SICFG_REG_VALLO     8'h02
`define SICFG_REG_FMT       8'h03
`define SICFG_ADDR_MIN      16'h0001
`define SICFG_ADDR_MAX      16'h00FF
`define SICFG_BAUD_MAX      16'h0007
`define SICFG_PERM_MAX      16'h0001
`define SICFG_DELAY_MAX     16'h0005
`define SICFG_BIT_MAX       16'h0001
`define SICFG_GAP_MAX       16'h0063
`define SICFG_BRI_MIN       16'h0001
`define SICFG_BRI_MAX       16'h0008
`define SICFG_TYPE_MAX      16'h0003
`define SICFG_ATTR_MASK     16'h900F
`define SICFG_FC_READ       8'h03
`define SICFG_FC_WRITE1     8'h06
`define SICFG_FC_WRITEN     8'h10
`define SICFG_EXC_NONE      8'h00
`define SICFG_EXC_FUNC      8'h01
`define SICFG_EXC_ADDR      8'h02
`define SICFG_EXC_DATA      8'h03
`define SICFG_EXC_PERM      8'h08
`define SICFG_RST_ADDR      8'h01
`define SICFG_RST_BAUD      3'h3
`define SICFG_RST_BRI       4'h8
`define SICFG_RST_ATTR      16'h8000
`define SICFG_DELAY_C1      10
`define SICFG_DELAY_C2      20
`define SICFG_DELAY_C3      50
`define SICFG_DELAY_C4      100
`define SICFG_DELAY_C5      200
`define SICFG_SECOND_NS     1000000000
`define SICFG_CLK_NS        20
`endif

// ==== sicfg_pkg.sv ====
// types shared by the configuration register bank
package sicfg_pkg;
    // request handling phases
    typedef enum logic [1:0] {
        SICFG_IDLE,
        SICFG_CHECK,
        SICFG_WAIT,
        SICFG_ANSWER
    } sicfg_state_t;

    // state of the bank except the frame gap supervision counters
    typedef struct packed {
        sicfg_state_t state;
        logic         is_write;
        logic [7:0]   func;
        logic [7:0]   reg_addr;
        logic [15:0]  wdata;
        logic         suppress;
        logic [7:0]   exc;
        logic [15:0]  rdata;
        logic [15:0]  attr2;
        logic [15:0]  attr3;
        logic [15:0]  attr4;
        logic [15:0]  attr5;
        logic [15:0]  attr6;
        logic [7:0]   addr_live;
        logic [7:0]   addr_pend;
        logic [2:0]   baud;
        logic         perm;
        logic [2:0]   delay_code;
        logic         val_reply;
        logic [6:0]   gap_s;
        logic [3:0]   bri;
        logic [3:0]   vbri;
        logic         edit;
        logic [1:0]   vtype;
        logic [15:0]  wait_cnt;
        logic         sync1;
        logic         sync2;
    } sicfg_state_s_t;
endpackage

// ==== sicfg_config_bank.sv ====
// configuration registers 19h..31h of the serial indicator with request checking
`timescale 1ns/1ps
`include "sicfg_regs.svh"
module sicfg_config_bank #(
    parameter bit          SIX_DECADES = 1'b0,        // variant select
    parameter logic [15:0] ID_FOUR     = 16'h0A04,    // arbitrary value
    parameter logic [15:0] ID_SIX      = 16'h0A06,    // arbitrary value
    parameter int          UNIT_C_CYC  = 50,          // cycles per delay unit 'c'
    parameter int          SECOND_CYC  = `SICFG_SECOND_NS / `SICFG_CLK_NS
) (
    input  wire logic        core_clk,          // system clock, 50 MHz
    input  wire logic        resetn,            // synchronous reset, active low
    input  wire logic        clk_en,            // freezes all state while low
    input  wire logic        req_valid,         // decoded frame for this slave
    input  wire logic [7:0]  req_func,          // function code
    input  wire logic [7:0]  req_reg,           // register address
    input  wire logic [15:0] req_wdata,         // value to write
    input  wire logic        menu_perm_set,     // front-panel permit, async pin
    input  wire logic        frame_rx,          // pulse per received frame
    output logic             req_ready,         // bank idle, request taken
    output logic             rsp_valid,         // answer ready, one cycle
    output logic             rsp_send,          // answer is to be transmitted
    output logic [7:0]       rsp_exc,           // 0 or exception code
    output logic [15:0]      rsp_rdata,         // read data
    output logic [7:0]       rsp_addr,          // address to answer with
    output logic [2:0]       baud_sel,          // active bit-rate code
    output logic [7:0]       slave_addr,        // active slave address
    output logic [3:0]       bright_level,      // brightness in use
    output logic             edit_slide,        // 1 = sliding edit
    output logic [1:0]       value_type,        // displayed value type
    output logic             gap_enable,        // gap supervision active
    output logic [6:0]       gap_seconds,       // gap limit
    output logic [79:0]      decade_attr,       // attributes decades 2..6
    output logic             write_enabled      // serial writes allowed
);
    sicfg_pkg::sicfg_state_s_t st_reg;          // registered state
    sicfg_pkg::sicfg_state_s_t st_next;         // next state

    // register implemented for the variant
    function automatic logic reg_exists(input logic [7:0] a);
        logic ok;
        ok = 1'b0;
        unique case (a)
            `SICFG_REG_DEC2, `SICFG_REG_DEC3, `SICFG_REG_DEC4,
            `SICFG_REG_ADDR, `SICFG_REG_IDENT, `SICFG_REG_BAUD,
            `SICFG_REG_PERM, `SICFG_REG_DELAY, `SICFG_REG_VALREPLY,
            `SICFG_REG_GAP, `SICFG_REG_BRI, `SICFG_REG_EDIT,
            `SICFG_REG_TYPE, `SICFG_REG_VBRI: ok = 1'b1;
            `SICFG_REG_DEC5, `SICFG_REG_DEC6: ok = SIX_DECADES;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // value range check per register
    function automatic logic value_ok(input logic [7:0] a, input logic [15:0] v);
        logic ok;
        ok = 1'b1;
        unique case (a)
            `SICFG_REG_ADDR:     ok = (v >= `SICFG_ADDR_MIN) && (v <= `SICFG_ADDR_MAX);
            `SICFG_REG_BAUD:     ok = v <= `SICFG_BAUD_MAX;
            `SICFG_REG_PERM:     ok = v <= `SICFG_PERM_MAX;
            `SICFG_REG_DELAY:    ok = v <= `SICFG_DELAY_MAX;
            `SICFG_REG_VALREPLY: ok = v <= `SICFG_BIT_MAX;
            `SICFG_REG_GAP:      ok = v <= `SICFG_GAP_MAX;
            `SICFG_REG_BRI,
            `SICFG_REG_VBRI:     ok = (v >= `SICFG_BRI_MIN) && (v <= `SICFG_BRI_MAX);
            `SICFG_REG_EDIT:     ok = v <= `SICFG_BIT_MAX;
            `SICFG_REG_TYPE:     ok = v <= `SICFG_TYPE_MAX;
            default:             ok = 1'b1;
        endcase
        return ok;
    endfunction

    // cycle count of the extra reply delay
    function automatic logic [15:0] delay_cycles(input logic [2:0] c);
        logic [15:0] n;
        n = 16'h0000;
        unique case (c)
            3'h1:    n = 16'(`SICFG_DELAY_C1 * UNIT_C_CYC);
            3'h2:    n = 16'(`SICFG_DELAY_C2 * UNIT_C_CYC);
            3'h3:    n = 16'(`SICFG_DELAY_C3 * UNIT_C_CYC);
            3'h4:    n = 16'(`SICFG_DELAY_C4 * UNIT_C_CYC);
            3'h5:    n = 16'(`SICFG_DELAY_C5 * UNIT_C_CYC);
            default: n = 16'h0000; // code 0: none
        endcase
        return n;
    endfunction

    // read mux
    function automatic logic [15:0] read_value(input sicfg_pkg::sicfg_state_s_t s);
        logic [15:0] r;
        r = 16'h0000;
        unique case (s.reg_addr)
            `SICFG_REG_DEC2:     r = s.attr2;
            `SICFG_REG_DEC3:     r = s.attr3;
            `SICFG_REG_DEC4:     r = s.attr4;
            `SICFG_REG_DEC5:     r = s.attr5;
            `SICFG_REG_DEC6:     r = s.attr6;
            `SICFG_REG_ADDR:     r = {8'h00, s.addr_live};
            `SICFG_REG_IDENT:    r = SIX_DECADES ? ID_SIX : ID_FOUR;
            `SICFG_REG_BAUD:     r = {13'h0, s.baud};
            `SICFG_REG_PERM:     r = {15'h0, s.perm};
            `SICFG_REG_DELAY:    r = {13'h0, s.delay_code};
            `SICFG_REG_VALREPLY: r = {15'h0, s.val_reply};
            `SICFG_REG_GAP:      r = {9'h0, s.gap_s};
            `SICFG_REG_BRI:      r = {12'h0, s.bri};
            `SICFG_REG_EDIT:     r = {15'h0, s.edit};
            `SICFG_REG_TYPE:     r = {14'h0, s.vtype};
            `SICFG_REG_VBRI:     r = {12'h0, s.vbri};
            default:             r = 16'h0000;
        endcase
        return r;
    endfunction

    // next-state logic
    always_comb begin
        logic        is_fn_ok;
        logic        is_wr;
        logic        is_value_reg;
        logic [15:0] v;
        st_next      = st_reg;
        is_fn_ok     = 1'b0;
        is_wr        = 1'b0;
        is_value_reg = 1'b0;
        v            = st_reg.wdata;
        // menu permit pin through two flip-flops
        st_next.sync1 = menu_perm_set;
        st_next.sync2 = st_reg.sync1;
        unique case (st_reg.state)
            sicfg_pkg::SICFG_IDLE: begin
                // capture one request
                if (req_valid) begin
                    st_next.func     = req_func;
                    st_next.reg_addr = req_reg;
                    st_next.wdata    = req_wdata;
                    st_next.state    = sicfg_pkg::SICFG_CHECK;
                end
            end
            sicfg_pkg::SICFG_CHECK: begin
                // classify and apply, priority func > perm > addr > data
                is_fn_ok = (st_reg.func == `SICFG_FC_READ) || (st_reg.func == `SICFG_FC_WRITE1)
                           || (st_reg.func == `SICFG_FC_WRITEN);
                is_wr    = (st_reg.func == `SICFG_FC_WRITE1) || (st_reg.func == `SICFG_FC_WRITEN);
                is_value_reg = (st_reg.reg_addr == `SICFG_REG_VALHI) || (st_reg.reg_addr == `SICFG_REG_VALLO)
                               || (st_reg.reg_addr == `SICFG_REG_FMT);
                st_next.is_write = is_wr;
                st_next.suppress = 1'b0;
                st_next.exc      = `SICFG_EXC_NONE;
                st_next.rdata    = 16'h0000;
                if (!is_fn_ok) begin
                    st_next.exc = `SICFG_EXC_FUNC;
                end else if (is_wr && !st_reg.perm) begin
                    st_next.exc = `SICFG_EXC_PERM;
                end else if (is_wr && is_value_reg) begin
                    st_next.suppress = !st_reg.val_reply;           // handled elsewhere, answered only while val_reply is set
                end else if (!reg_exists(st_reg.reg_addr)) begin
                    st_next.exc = `SICFG_EXC_ADDR;
                end else if (is_wr && st_reg.reg_addr == `SICFG_REG_IDENT) begin
                    st_next.exc = `SICFG_EXC_ADDR;                  // read only
                end else if (is_wr && !value_ok(st_reg.reg_addr, v)) begin
                    st_next.exc = `SICFG_EXC_DATA;                  // unchanged
                end else if (is_wr && st_reg.reg_addr == `SICFG_REG_PERM && v[0]) begin
                    st_next.exc = `SICFG_EXC_DATA;                  // cannot unblock serially
                end else if (!is_wr) begin
                    st_next.rdata = read_value(st_reg);
                end else begin
                    st_next.rdata = v;
                    unique case (st_reg.reg_addr)
                        `SICFG_REG_DEC2:     st_next.attr2 = v & `SICFG_ATTR_MASK;
                        `SICFG_REG_DEC3:     st_next.attr3 = v & `SICFG_ATTR_MASK;
                        `SICFG_REG_DEC4:     st_next.attr4 = v & `SICFG_ATTR_MASK;
                        `SICFG_REG_DEC5:     st_next.attr5 = v & `SICFG_ATTR_MASK;
                        `SICFG_REG_DEC6:     st_next.attr6 = v & `SICFG_ATTR_MASK;
                        `SICFG_REG_ADDR:     st_next.addr_pend = v[7:0];            // after answer
                        `SICFG_REG_BAUD:     st_next.baud = v[2:0];                 // before answer
                        `SICFG_REG_PERM:     st_next.perm = 1'b0;
                        `SICFG_REG_DELAY:    st_next.delay_code = v[2:0];
                        `SICFG_REG_VALREPLY: st_next.val_reply = v[0];
                        `SICFG_REG_GAP:      st_next.gap_s = v[6:0];
                        `SICFG_REG_BRI: begin
                            st_next.bri  = v[3:0];
                            st_next.vbri = v[3:0];                                  // display follows
                        end
                        `SICFG_REG_EDIT:     st_next.edit = v[0];
                        `SICFG_REG_TYPE:     st_next.vtype = v[1:0];
                        `SICFG_REG_VBRI:     st_next.vbri = v[3:0];                 // not stored
                        default:             st_next.rdata = v;
                    endcase
                end
                st_next.wait_cnt = delay_cycles(st_reg.delay_code);
                st_next.state    = sicfg_pkg::SICFG_WAIT;
            end
            sicfg_pkg::SICFG_WAIT: begin
                // extra reply delay
                if (st_reg.wait_cnt == 16'h0000) begin
                    st_next.state = sicfg_pkg::SICFG_ANSWER;
                end else begin
                    st_next.wait_cnt = st_reg.wait_cnt - 16'h0001;
                end
            end
            sicfg_pkg::SICFG_ANSWER: begin
                // answer presented this cycle, then the new address takes over
                st_next.addr_live = st_reg.addr_pend;
                st_next.state     = sicfg_pkg::SICFG_IDLE;
            end
        endcase
        // panel permit last, so it beats a serial clear
        if (st_reg.sync2) begin
            st_next.perm = 1'b1; // panel re-enables
        end
    end

    // state register
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            st_reg            <= '0;
            st_reg.attr2      <= `SICFG_RST_ATTR;
            st_reg.attr3      <= `SICFG_RST_ATTR;
            st_reg.attr4      <= `SICFG_RST_ATTR;
            st_reg.attr5      <= `SICFG_RST_ATTR;
            st_reg.attr6      <= `SICFG_RST_ATTR;
            st_reg.addr_live  <= `SICFG_RST_ADDR;
            st_reg.addr_pend  <= `SICFG_RST_ADDR;
            st_reg.baud       <= `SICFG_RST_BAUD;
            st_reg.perm       <= 1'b1;
            st_reg.val_reply  <= 1'b1;
            st_reg.bri        <= `SICFG_RST_BRI;
            st_reg.vbri       <= `SICFG_RST_BRI;                    // power-up uses stored level
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    // frame gap supervision, seconds since last frame
    logic [31:0] gap_tick_reg;                  // cycles inside a second
    logic [6:0]  gap_sec_reg;                   // elapsed seconds
    logic        gap_expired_reg;               // limit passed
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            gap_tick_reg    <= 32'h0;
            gap_sec_reg     <= 7'h00;
            gap_expired_reg <= 1'b0;
        end else if (clk_en) begin
            if (frame_rx || st_reg.gap_s == 7'h00) begin
                gap_tick_reg    <= 32'h0; // restart or disabled
                gap_sec_reg     <= 7'h00;
                gap_expired_reg <= 1'b0;
            end else if (gap_tick_reg == 32'(SECOND_CYC - 1)) begin
                gap_tick_reg <= 32'h0;
                if (gap_sec_reg != 7'h7F) begin
                    gap_sec_reg <= gap_sec_reg + 7'h01;
                end
                if (gap_sec_reg + 7'h01 >= st_reg.gap_s) begin
                    gap_expired_reg <= 1'b1;
                end
            end else begin
                gap_tick_reg <= gap_tick_reg + 32'h1;
            end
        end
    end

    // outputs
    assign req_ready     = st_reg.state == sicfg_pkg::SICFG_IDLE;
    assign rsp_valid     = st_reg.state == sicfg_pkg::SICFG_ANSWER;
    assign rsp_send      = !st_reg.suppress;
    assign rsp_exc       = st_reg.exc;
    assign rsp_rdata     = st_reg.rdata;
    assign rsp_addr      = st_reg.addr_live;                        // old address
    assign baud_sel      = st_reg.baud;
    assign slave_addr    = st_reg.addr_live;
    assign bright_level  = st_reg.vbri;
    assign edit_slide    = st_reg.edit;
    assign value_type    = st_reg.vtype;
    assign gap_enable    = st_reg.gap_s != 7'h00;
    assign gap_seconds   = st_reg.gap_s;
    assign decade_attr   = {st_reg.attr6, st_reg.attr5, st_reg.attr4, st_reg.attr3, st_reg.attr2};
    assign write_enabled = st_reg.perm;
endmodule

// ==== sicfg_master_model.sv ====
// serial master stand-in that issues one register request at a time
`timescale 1ns/1ps
module sicfg_master_model (
    input  wire logic        core_clk,
    input  wire logic        start,
    input  wire logic [7:0]  f,
    input  wire logic [7:0]  r,
    input  wire logic [15:0] d,
    input  wire logic        req_ready,
    input  wire logic        rsp_valid,
    output logic             req_valid,
    output logic [7:0]       req_func,
    output logic [7:0]       req_reg,
    output logic [15:0]      req_wdata,
    output logic             done
);
    // lines start quiet
    initial {req_valid, req_func, req_reg, req_wdata, done} = '0;
    // hold a request until taken, then scramble the released lines
    always @(posedge core_clk) begin
        done <= rsp_valid;
        if (req_valid && req_ready) begin
            req_valid <= 1'b0;
            req_func  <= ~req_func;
            req_reg   <= ~req_reg;
            req_wdata <= ~req_wdata;
        end else if (start && !req_valid) begin
            req_valid <= 1'b1;
            req_func  <= f;
            req_reg   <= r;
            req_wdata <= d;
        end
    end
endmodule

// ==== sicfg_config_bank_chk.sv ====
// port-level assertions for the configuration register bank
`timescale 1ns/1ps
module sicfg_config_bank_chk #(
    parameter logic [15:0] ID_FOUR = 16'h0A04
) (
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic        clk_en,
    input wire logic        req_valid,
    input wire logic [7:0]  req_func,
    input wire logic [7:0]  req_reg,
    input wire logic [15:0] req_wdata,
    input wire logic        menu_perm_set,
    input wire logic        req_ready,
    input wire logic        rsp_valid,
    input wire logic        rsp_send,
    input wire logic [7:0]  rsp_exc,
    input wire logic [15:0] rsp_rdata,
    input wire logic [7:0]  rsp_addr,
    input wire logic [2:0]  baud_sel,
    input wire logic [7:0]  slave_addr,
    input wire logic [3:0]  bright_level,
    input wire logic [79:0] decade_attr,
    input wire logic        write_enabled
);
    logic [7:0]  f_q;  // function of taken request
    logic [7:0]  r_q;  // register of taken request
    logic [15:0] d_q;  // value of taken request
    logic [7:0]  a_q;  // address in use when taken
    logic        p_q;  // permission when taken
    logic [14:0] s_q;  // settings when taken
    wire logic   acc = req_valid && req_ready && clk_en;
    wire logic   wr  = f_q == 8'h06 || f_q == 8'h10;
    // remember each request as it is taken
    always_ff @(posedge core_clk) begin
        if (acc) begin
            f_q <= req_func;
            r_q <= req_reg;
            d_q <= req_wdata;
            a_q <= slave_addr;
            p_q <= write_enabled;
            s_q <= {baud_sel, slave_addr, bright_level};
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    property p_answer; acc |=> !rsp_valid [*2] ##[1:1000] rsp_valid; endproperty
    a_answer: assert property (p_answer) else $error("request got no answer");
    property p_func; rsp_valid && !wr && f_q != 8'h03 |-> rsp_exc == 8'h01; endproperty
    a_func: assert property (p_func) else $error("bad function not refused");
    property p_perm; rsp_valid && wr && !p_q |-> rsp_exc == 8'h08; endproperty
    a_perm: assert property (p_perm) else $error("write passed while locked");
    property p_baud; rsp_valid && !rsp_exc && wr && r_q == 8'h22 |-> baud_sel == d_q[2:0]; endproperty
    a_baud: assert property (p_baud) else $error("rate not new at reply");
    property p_addr;
        rsp_valid && !rsp_exc && wr && r_q == 8'h20 |-> rsp_addr == a_q ##1 slave_addr == d_q[7:0];
    endproperty
    a_addr: assert property (p_addr) else $error("address switch order wrong");
    property p_keep;
        rsp_valid && rsp_exc == 8'h03 |-> ##1 {baud_sel, slave_addr, bright_level} == s_q;
    endproperty
    a_keep: assert property (p_keep) else $error("rejected write changed a setting");
    property p_unlock;
        !write_enabled ##1 write_enabled |-> $past(menu_perm_set, 2) || $past(menu_perm_set, 3)
            || $past(menu_perm_set, 4);
    endproperty
    a_unlock: assert property (p_unlock) else $error("permission set without panel");
    property p_ident; rsp_valid && !rsp_exc && f_q == 8'h03 && r_q == 8'h21 |-> rsp_rdata == ID_FOUR; endproperty
    a_ident: assert property (p_ident) else $error("identification wrong");
    property p_attr; (decade_attr & {5{16'h6FF0}}) == 80'h0; endproperty
    a_attr: assert property (p_attr) else $error("reserved attribute bit set");
    c_locked: cover property (rsp_valid && rsp_exc == 8'h08);
    c_quiet: cover property (rsp_valid && !rsp_send);
    c_rate: cover property (rsp_valid && wr && r_q == 8'h22);
endmodule
bind sicfg_config_bank sicfg_config_bank_chk #(.ID_FOUR(ID_FOUR)) sicfg_config_bank_chk_inst (
    .core_clk, .resetn, .clk_en, .req_valid, .req_func, .req_reg, .req_wdata, .menu_perm_set, .req_ready,
    .rsp_valid, .rsp_send, .rsp_exc, .rsp_rdata, .rsp_addr, .baud_sel, .slave_addr, .bright_level,
    .decade_attr, .write_enabled);

// ==== tb_serial_indicator_config_registers.sv ====
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
module tb_serial_indicator_config_registers;
    localparam int          UNIT = 2;        // shortened delay unit
    localparam logic [15:0] ID4  = 16'h1234; // arbitrary value
    logic        core_clk, resetn, menu_perm_set, frame_rx, start, done, req_valid, req_ready;
    logic        rsp_valid, rsp_send, edit_slide, gap_enable, write_enabled;
    logic [7:0]  req_func, req_reg, rsp_exc, rsp_addr, slave_addr, st_f, st_r, ra;
    logic [15:0] req_wdata, rsp_rdata, st_d;
    logic [2:0]  baud_sel;
    logic [3:0]  bright_level;
    logic [1:0]  value_type;
    logic [6:0]  gap_seconds;
    logic [79:0] decade_attr;
    int          failures, samples_checked, n, base;
    int          dc[6] = '{0, 10, 20, 50, 100, 200};
    sicfg_config_bank #(.ID_FOUR(ID4), .UNIT_C_CYC(UNIT), .SECOND_CYC(100)) sicfg_config_bank_inst (
        .core_clk, .resetn, .clk_en(1'b1), .req_valid, .req_func, .req_reg, .req_wdata, .menu_perm_set,
        .frame_rx, .req_ready, .rsp_valid, .rsp_send, .rsp_exc, .rsp_rdata, .rsp_addr, .baud_sel, .slave_addr,
        .bright_level, .edit_slide, .value_type, .gap_enable, .gap_seconds, .decade_attr, .write_enabled);
    sicfg_master_model sicfg_master_model_inst (
        .core_clk, .start, .f(st_f), .r(st_r), .d(st_d), .req_ready, .rsp_valid, .req_valid, .req_func,
        .req_reg, .req_wdata, .done);
    // clock, 20 ns period
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // compare one result
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one request through the master, n counts edges to the answer
    task automatic req(input logic [7:0] f, input logic [7:0] r, input logic [15:0] d);
        st_f <= f;
        st_r <= r;
        st_d <= d;
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        n = 0;
        while (!done && n < 2000) begin
            @(posedge core_clk);
            n++;
            if (rsp_valid) ra = rsp_addr; // address while the answer stands
        end
        if (!done) failures++;
    endtask
    // request and judge the exception code and data
    task automatic chk(input logic [7:0] f, r, input logic [15:0] d, input logic [7:0] ex, input logic [15:0] rd);
        req(f, r, d);
        check({8'h00, rsp_exc}, {8'h00, ex});
        if (ex == 8'h00) check(rsp_rdata, rd);
    endtask
    // closing verdict
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic t_reset();
        check({13'h0, baud_sel}, 16'h0003);
        check({8'h00, slave_addr}, 16'h0001);
        check({12'h0, bright_level}, 16'h0008);
        check(decade_attr[79:64], 16'h8000);
        $display("reset test done");
    endtask
    task automatic t_addr_rate();
        chk(8'h06, 8'h20, 16'h0007, 8'h00, 16'h0007);
        check({8'h00, ra}, 16'h0001);
        check({8'h00, slave_addr}, 16'h0007);
        chk(8'h06, 8'h20, 16'h00FF, 8'h00, 16'h00FF);
        chk(8'h06, 8'h20, 16'h0000, 8'h03, 16'h0000);
        chk(8'h06, 8'h20, 16'h0100, 8'h03, 16'h0000);
        for (int k = 0; k < 8; k++) begin
            chk(8'h06, 8'h22, k[15:0], 8'h00, k[15:0]);
            check({13'h0, baud_sel}, k[15:0]);
        end
        $display("address and rate test done");
    endtask
    task automatic t_errors();
        logic [7:0] bf[3] = '{8'h01, 8'h04, 8'h05};
        for (int k = 0; k < 3; k++) chk(bf[k], 8'h20, 16'h0001, 8'h01, 16'h0000);
        chk(8'h03, 8'h24, 16'h0001, 8'h02, 16'h0000);
        chk(8'h06, 8'h1C, 16'h0001, 8'h02, 16'h0000);
        chk(8'h03, 8'h21, 16'h0001, 8'h00, ID4);
        chk(8'h06, 8'h21, 16'h0001, 8'h02, 16'h0000);
        chk(8'h10, 8'h19, 16'hFFFF, 8'h00, 16'hFFFF);
        chk(8'h03, 8'h19, 16'h0001, 8'h00, 16'h900F);
        $display("error test done");
    endtask
    task automatic t_ranges();
        logic [7:0]  br[9] = '{8'h22, 8'h25, 8'h26, 8'h27, 8'h2D, 8'h2D, 8'h2F, 8'h30, 8'h31};
        logic [15:0] bv[9] = '{16'h8, 16'h6, 16'h2, 16'h64, 16'h0, 16'h9, 16'h2, 16'h4, 16'h9};
        for (int k = 0; k < 9; k++) chk(8'h06, br[k], bv[k], 8'h03, 16'h0000);
        chk(8'h06, 8'h2F, 16'h0001, 8'h00, 16'h0001);
        check({15'h0, edit_slide}, 16'h0001);
        chk(8'h06, 8'h30, 16'h0003, 8'h00, 16'h0003);
        check({14'h0, value_type}, 16'h0003);
        chk(8'h06, 8'h27, 16'h0063, 8'h00, 16'h0063);
        check({8'h00, gap_enable, gap_seconds}, 16'h00E3);
        chk(8'h06, 8'h31, 16'h0002, 8'h00, 16'h0002);
        check({12'h0, bright_level}, 16'h0002);
        chk(8'h06, 8'h2D, 16'h0005, 8'h00, 16'h0005);
        $display("range test done");
    endtask
    task automatic t_delay_reply();
        for (int k = 0; k < 6; k++) begin
            chk(8'h06, 8'h25, k[15:0], 8'h00, k[15:0]);
            req(8'h03, 8'h2D, 16'h0001);
            if (k == 0) base = n;
            check(16'(n - base), 16'(dc[k] * UNIT));
        end
        chk(8'h06, 8'h25, 16'h0000, 8'h00, 16'h0000);
        chk(8'h06, 8'h26, 16'h0000, 8'h00, 16'h0000);
        req(8'h06, 8'h02, 16'h0010);
        check({15'h0, rsp_send}, 16'h0000);
        chk(8'h06, 8'h26, 16'h0001, 8'h00, 16'h0001);
        req(8'h06, 8'h03, 16'h0001);
        check({15'h0, rsp_send}, 16'h0001);
        $display("delay and reply test done");
    endtask
    task automatic t_perm();
        chk(8'h06, 8'h23, 16'h0001, 8'h03, 16'h0000);
        chk(8'h06, 8'h23, 16'h0000, 8'h00, 16'h0000);
        check({15'h0, write_enabled}, 16'h0000);
        chk(8'h06, 8'h2D, 16'h0003, 8'h08, 16'h0000);
        chk(8'h03, 8'h2D, 16'h0001, 8'h00, 16'h0005);
        menu_perm_set <= 1'b1;
        repeat (5) @(posedge core_clk);
        menu_perm_set <= 1'b0;
        frame_rx <= 1'b1;
        @(posedge core_clk);
        frame_rx <= 1'b0;
        check({15'h0, write_enabled}, 16'h0001);
        $display("permission test done");
    endtask
    // main sequence
    initial begin
        {resetn, menu_perm_set, frame_rx, start, st_f, st_r, st_d} = '0;
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        t_reset();
        t_addr_rate();
        t_errors();
        t_ranges();
        t_delay_reply();
        t_perm();
        summarize();
    end
    // cut a hang short
    initial begin
        repeat (30000) @(posedge core_clk);
        failures++;
        summarize();
    end
endmodule
